// ===== rtl/overrange_detect_and_trim.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "ovr_map.svh"
module overrange_detect_and_trim
  import ovr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // raw offset-binary core samples
  input wire logic [7:0] core_a_raw,
  input wire logic [7:0] core_b_raw,
  // trimmed samples
  output logic [7:0] chan_a_sample,
  output logic [7:0] chan_b_sample,
  // overrange flags
  output logic chan_a_upper_flag_out,
  output logic chan_a_lower_flag_out,
  output logic chan_b_upper_flag_out,
  output logic chan_b_lower_flag_out,
  // analog front end controls
  output logic [7:0] input_a_full_scale_setting,
  output logic [7:0] input_b_full_scale_setting,
  output logic falling_edge_sampling,
  output logic active_input_select,
  output logic calibration_start,
  // interrupt
  output logic irq
);
  ctrl_t ctrl;
  thresh_t thr;
  logic [3:0] stat;
  logic [3:0] mask;
  logic [3:0] flags_prev;
  logic [7:0] trim [0:5];
  logic [1:0] flag_a;
  logic [1:0] flag_b;

  // bus decode
  wire logic [9:0] idx = paddr[11:2];
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready & pwrite;
  wire logic sel_ctrl = idx == `IDX_CTRL;
  wire logic sel_thr = idx == `IDX_THRESH;
  wire logic sel_fs_a = idx == `IDX_FS_A;
  wire logic sel_fs_b = idx == `IDX_FS_B;
  wire logic sel_stat = idx == `IDX_STATUS;
  wire logic sel_mask = idx == `IDX_MASK;
  wire logic sel_live = idx == `IDX_LIVE;
  wire logic sel_trim = idx >= `IDX_TRIM_FIRST && idx <= `IDX_TRIM_LAST;
  wire logic [2:0] trim_i = 3'(idx - `IDX_TRIM_FIRST);
  wire logic mapped = sel_ctrl | sel_thr | sel_fs_a | sel_fs_b | sel_stat | sel_mask | sel_live | sel_trim;
  wire logic [3:0] flags = {flag_b, flag_a};
  wire logic [31:0] rd_mux =
    sel_ctrl ? {27'h0, ctrl} :
    sel_thr ? {16'h0, thr.lower, thr.upper} :
    sel_fs_a ? {24'h0, input_a_full_scale_setting} :
    sel_fs_b ? {24'h0, input_b_full_scale_setting} :
    sel_stat ? {28'h0, stat} :
    sel_mask ? {28'h0, mask} :
    sel_live ? {27'h0, active_input_select, flags} :
    sel_trim ? {24'h0, trim[trim_i]} : 32'h0;

  // events and interrupt
  wire logic [3:0] ev = flags & ~flags_prev;
  wire logic [3:0] clr = (wr_en && sel_stat) ? pwdata[3:0] : 4'h0;
  wire logic [3:0] next_stat = (stat & ~clr) | ev;
  wire logic [3:0] next_mask = (wr_en && sel_mask) ? pwdata[3:0] : mask;

  // trim selection: dual mode gives core A its own dual trim and core B the input B trim
  wire logic [2:0] a_sel = ctrl.single_mode ? `TRIM_A_SINGLE + 3'(active_input_select) : `TRIM_A_DUAL;
  wire logic [2:0] b_sel = `TRIM_B + 3'(ctrl.single_mode ? active_input_select : 1'b1);
  wire logic [7:0] trim_a_sel = trim[a_sel];
  wire logic [7:0] trim_b_sel = trim[b_sel];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0;
      thr <= '{upper: `RST_UPPER, lower: `RST_LOWER};
      input_a_full_scale_setting <= `RST_FS;
      input_b_full_scale_setting <= `RST_FS;
      for (int i = 0; i < 6; i++)
        trim[i] <= 8'h00;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
        ctrl <= ctrl_t'(pwdata[`CTRL_INSEL:`CTRL_SINGLE]);
      if (sel_thr)
        thr <= '{upper: pwdata[7:0], lower: pwdata[`THR_LOWER_LSB+7:`THR_LOWER_LSB]};
      if (sel_fs_a)
        input_a_full_scale_setting <= pwdata[7:0];
      if (sel_fs_b)
        input_b_full_scale_setting <= pwdata[7:0];
      if (sel_trim)
        trim[trim_i] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat <= 4'h0;
      mask <= 4'h0;
      flags_prev <= 4'h0;
      irq <= 1'b0;
      calibration_start <= 1'b0;
      active_input_select <= 1'b0;
      falling_edge_sampling <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      mask <= next_mask;
      flags_prev <= flags;
      irq <= |(next_stat & next_mask);
      calibration_start <= wr_en & sel_ctrl & pwdata[`CTRL_CAL];
      if (calibration_start)
        active_input_select <= ctrl.input_sel;
      falling_edge_sampling <= ctrl.single_mode;
    end
  end

  offset_trim_stage trim_a (
    .pclk(pclk),
    .presetn(presetn),
    .raw_sample(core_a_raw),
    .trim(trim_a_sel),
    .sample(chan_a_sample)
  );

  offset_trim_stage trim_b (
    .pclk(pclk),
    .presetn(presetn),
    .raw_sample(core_b_raw),
    .trim(trim_b_sel),
    .sample(chan_b_sample)
  );

  // same thresholds and hold length for both channels
  overrange_channel ovr_a (
    .pclk(pclk),
    .presetn(presetn),
    .sample(chan_a_sample),
    .thr(thr),
    .hold_sel(ctrl.hold_sel),
    .flag(flag_a)
  );

  overrange_channel ovr_b (
    .pclk(pclk),
    .presetn(presetn),
    .sample(chan_b_sample),
    .thr(thr),
    .hold_sel(ctrl.hold_sel),
    .flag(flag_b)
  );

  // index 1 upper, index 0 lower per channel
  assign chan_a_upper_flag_out = flag_a[1];
  assign chan_a_lower_flag_out = flag_a[0];
  assign chan_b_upper_flag_out = flag_b[1];
  assign chan_b_lower_flag_out = flag_b[0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_apb_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not in one cycle");

  property p_shared_thr;
    wr_en && sel_thr |=> thr.upper == $past(pwdata[7:0]) && thr.lower == $past(pwdata[15:8]);
  endproperty
  a_shared_thr: assert property (p_shared_thr) else $error("threshold write lost");

  property p_hold_write;
    wr_en && sel_ctrl |=> ctrl.hold_sel == $past(pwdata[`CTRL_HOLD_MSB:`CTRL_HOLD_LSB]);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold select not written");

  property p_twos;
    trim[`TRIM_A_DUAL] == 8'h00 && !ctrl.single_mode
      |=> chan_a_sample == {~$past(core_a_raw[7]), $past(core_a_raw[6:0])};
  endproperty
  a_twos: assert property (p_twos) else $error("sample not two's complement");

  property p_trim;
    core_a_raw == `MOST_NEG |=> chan_a_sample == $past(trim_a_sel);
  endproperty
  a_trim: assert property (p_trim) else $error("wrong offset trim applied");

  property p_mux_needs_cal;
    !calibration_start |=> $stable(active_input_select);
  endproperty
  a_mux_needs_cal: assert property (p_mux_needs_cal) else $error("input changed without calibration");

  property p_cal_applies;
    calibration_start |=> active_input_select == $past(ctrl.input_sel);
  endproperty
  a_cal_applies: assert property (p_cal_applies) else $error("calibration did not apply input");

  property p_edge_mode;
    wr_en && sel_ctrl ##1 !(wr_en && sel_ctrl) |=> falling_edge_sampling == $past(ctrl.single_mode);
  endproperty
  a_edge_mode: assert property (p_edge_mode) else $error("edge mode not following mode");

  property p_set_wins;
    ev[0] && wr_en && sel_stat && pwdata[0] |=> stat[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost during clear");

  property p_irq;
    $rose(chan_a_upper_flag_out) && mask[1] && !(wr_en && sel_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event without interrupt");

  property p_apb_err;
    setup && !mapped |=> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped index without error");

  property p_unmapped_ignored;
    wr_en && !mapped |=> $stable(ctrl) && $stable(thr);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write changed a register");

  property p_b_trim;
    core_b_raw == `MOST_NEG |=> chan_b_sample == $past(trim_b_sel);
  endproperty
  a_b_trim: assert property (p_b_trim) else $error("core b trim not applied");

  property p_trim_write;
    wr_en && sel_trim |=> trim[$past(trim_i)] == $past(pwdata[7:0]);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_fs_b_write;
    wr_en && sel_fs_b |=> input_b_full_scale_setting == $past(pwdata[7:0]);
  endproperty
  a_fs_b_write: assert property (p_fs_b_write) else $error("input b full scale write lost");

  property p_cal_pulse;
    calibration_start |=> !calibration_start;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start longer than one cycle");

  property p_a_upper_map;
    $rose(chan_a_upper_flag_out) |=> stat[1];
  endproperty
  a_a_upper_map: assert property (p_a_upper_map) else $error("a upper flag not in status bit 1");

  property p_b_lower_map;
    $rose(chan_b_lower_flag_out) |=> stat[2];
  endproperty
  a_b_lower_map: assert property (p_b_lower_map) else $error("b lower flag not in status bit 2");

  property p_cov_set_wins;
    ev[0] && wr_en && sel_stat && pwdata[0];
  endproperty
  c_set_wins: cover property (p_cov_set_wins);

  property p_cov_irq;
    $rose(irq);
  endproperty
  c_irq: cover property (p_cov_irq);

  property p_cov_cal;
    calibration_start && ctrl.single_mode;
  endproperty
  c_cal: cover property (p_cov_cal);

  property p_cov_both;
    chan_a_upper_flag_out && chan_b_lower_flag_out;
  endproperty
  c_both: cover property (p_cov_both);
endmodule

// ===== rtl/ovr_map.svh
`ifndef OVR_MAP_SVH
`define OVR_MAP_SVH
// Operation
// - both channels share the two thresholds
// - magnitude is abs value, saturating at 127
// - flag set when magnitude reaches threshold
// - per channel: index 1 upper, 0 lower
// - hold length 8 doubling up to 1024 cycles
// - output samples are two's complement
// - single mode also samples on falling edge
// - offset trims per core and input, and per mode for core A only
// - separate full scale setting per input
// - new input selection needs calibration first
`define IDX_CTRL 10'h000
`define IDX_THRESH 10'h001
`define IDX_FS_A 10'h002
`define IDX_FS_B 10'h003
`define IDX_STATUS 10'h004
`define IDX_MASK 10'h005
`define IDX_LIVE 10'h006
`define IDX_TRIM_FIRST 10'h344
`define IDX_TRIM_LAST 10'h349
`define TRIM_A_DUAL 3'h0
`define TRIM_A_SINGLE 3'h2
`define TRIM_B 3'h4
`define CTRL_SINGLE 0
`define CTRL_HOLD_LSB 1
`define CTRL_HOLD_MSB 3
`define CTRL_INSEL 4
`define CTRL_CAL 5
`define THR_LOWER_LSB 8
`define RST_UPPER 8'hE4
`define RST_LOWER 8'h40
`define RST_FS 8'h00
`define HOLD_BASE 11'h008
`define MAG_MAX 7'h7F
`define MOST_NEG 8'h80
`endif

// ===== rtl/ovr_pkg.sv
package ovr_pkg;
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } thresh_t;
  typedef struct packed {
    logic input_sel;
    logic [2:0] hold_sel;
    logic single_mode;
  } ctrl_t;
  function automatic logic [7:0] sat_add(input logic [7:0] s, input logic [7:0] t);
    logic [8:0] sum;
    sum = {s[7], s} + {t[7], t};
    if (sum[8] != sum[7])
    begin
      sum[7:0] = sum[8] ? 8'h80 : 8'h7F;
    end
    return sum[7:0];
  endfunction
endpackage

// ===== rtl/offset_trim_stage.sv
`timescale 1ns/10ps
`include "ovr_map.svh"
module offset_trim_stage
  import ovr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw offset-binary sample and trim
  input wire logic [7:0] raw_sample,
  input wire logic [7:0] trim,
  // trimmed two's complement sample
  output logic [7:0] sample
);
  wire logic [7:0] twos = {~raw_sample[7], raw_sample[6:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample <= 8'h00;
    else
      sample <= sat_add(twos, trim);
  end
endmodule

// ===== rtl/overrange_channel.sv
`timescale 1ns/10ps
`include "ovr_map.svh"
module overrange_channel
  import ovr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sample and settings
  input wire logic [7:0] sample,
  input wire thresh_t thr,
  input wire logic [2:0] hold_sel,
  // flags: bit 1 upper, bit 0 lower
  output logic [1:0] flag
);
  logic [1:0][10:0] cnt;
  wire logic [6:0] neg_mag = 7'(8'h00 - sample);
  wire logic [6:0] mag = !sample[7] ? sample[6:0] :
    (sample == `MOST_NEG) ? `MAG_MAX : neg_mag;
  wire logic [1:0] hit = {{1'b0, mag} >= thr.upper, {1'b0, mag} >= thr.lower};
  wire logic [10:0] hold_len = `HOLD_BASE << hold_sel;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      flag <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (hit[i])
        begin
          cnt[i] <= hold_len - 11'h001;
          flag[i] <= 1'b1;
        end
        else if (cnt[i] != 11'h000)
          cnt[i] <= cnt[i] - 11'h001;
        else
          flag[i] <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hold_min;
    hit[1] && hold_sel == 3'h0 |=> flag[1] [*8];
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("upper flag shorter than 8 cycles");

  property p_hold_end;
    (hit[1] && hold_sel == 3'h0) ##1 (!hit[1] && hold_sel == 3'h0) [*8] |=> !flag[1];
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("upper flag held past 8 cycles");

  property p_most_neg;
    sample == `MOST_NEG && thr.lower == 8'h7F |=> flag[0];
  endproperty
  a_most_neg: assert property (p_most_neg) else $error("most negative code not 127");

  property p_quiet;
    !hit[0] && cnt[0] == 11'h000 |=> !flag[0];
  endproperty
  a_quiet: assert property (p_quiet) else $error("lower flag set without exceedance");
endmodule

// ===== sim/flag_watcher.sv
`timescale 1ns/10ps
module flag_watcher
(
  // clock
  input wire logic pclk,
  // flags and mode from the converter
  input wire logic a_up,
  input wire logic b_up,
  input wire logic single_mode,
  // measured upper pulse
  output logic [15:0] up_len,
  output logic up_done
);
  logic [15:0] cnt;
  wire logic up_any = single_mode ? (a_up | b_up) : a_up;
  initial
  begin
    cnt = 16'h0000;
    up_len = 16'h0000;
    up_done = 1'b0;
  end
  // length of each upper pulse in clock cycles
  always @(posedge pclk)
  begin
    up_done <= 1'b0;
    if (up_any === 1'b1)
      cnt <= cnt + 16'h0001;
    else if (cnt != 16'h0000)
    begin
      up_len <= cnt;
      up_done <= 1'b1;
      cnt <= 16'h0000;
    end
  end
endmodule

// ===== sim/overrange_detect_and_trim_test.sv
`timescale 1ns/10ps
`include "ovr_map.svh"
module overrange_detect_and_trim_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] core_a_raw = 8'h80;
  logic [7:0] core_b_raw = 8'h80;
  logic [31:0] prdata;
  logic pready, pslverr, fa_u, fa_l, fb_u, fb_l, fes, ais, cal, irq, up_done;
  logic [7:0] sa, sb, fs_a, fs_b;
  logic [15:0] up_len;
  logic [33:0] ae;
  logic [15:0] se;
  logic [33:0] apb_q[$];
  logic [15:0] smp_q[$];
  logic [15:0] len_q[$];
  int n_fail = 0;
  int total_checks = 0;
  always #10 pclk = ~pclk;
  overrange_detect_and_trim overrange_detect_and_trim_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_a_raw(core_a_raw), .core_b_raw(core_b_raw), .chan_a_sample(sa), .chan_b_sample(sb),
    .chan_a_upper_flag_out(fa_u), .chan_a_lower_flag_out(fa_l), .chan_b_upper_flag_out(fb_u),
    .chan_b_lower_flag_out(fb_l), .input_a_full_scale_setting(fs_a), .input_b_full_scale_setting(fs_b),
    .falling_edge_sampling(fes), .active_input_select(ais), .calibration_start(cal), .irq(irq));
  flag_watcher flag_watcher_inst (.pclk(pclk), .a_up(fa_u), .b_up(fb_u), .single_mode(fes), .up_len(up_len),
    .up_done(up_done));
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    apb_q.push_back({w, err, d});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      n_fail++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task smp(input logic [7:0] a, input logic [7:0] b, input logic [7:0] ea, input logic [7:0] eb);
    @(posedge pclk);
    core_a_raw <= a;
    core_b_raw <= b;
    @(posedge pclk);
    smp_q.push_back({ea, eb});
  endtask
  // one-cycle full-scale negative sample on both cores
  task hit;
    @(posedge pclk);
    core_a_raw <= 8'h00;
    core_b_raw <= 8'h00;
    @(posedge pclk);
    core_a_raw <= 8'h80;
    core_b_raw <= 8'h80;
  endtask
  task drain;
    int n;
    n = 0;
    while (len_q.size() > 0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      ae = apb_q.pop_front();
      chk("pslverr", {31'h0, ae[32]}, {31'h0, pslverr});
      if (!ae[33])
        chk("prdata", ae[31:0], prdata);
    end
  always @(negedge pclk)
    if (smp_q.size() > 0)
    begin
      se = smp_q.pop_front();
      chk("sample_a", {24'h0, se[15:8]}, {24'h0, sa});
      chk("sample_b", {24'h0, se[7:0]}, {24'h0, sb});
    end
  always @(posedge pclk)
    if (up_done === 1'b1)
    begin
      if (len_q.size() == 0)
        chk("pulse_unexpected", 32'h0, {16'h0, up_len});
      else
        chk("pulse_len", {16'h0, len_q.pop_front()}, {16'h0, up_len});
    end
  initial
  begin
    logic [7:0] a, b;
    int k;
    void'($urandom(32'h2DC3DBCF));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `IDX_THRESH, {16'h0, `RST_LOWER, `RST_UPPER}, 0);
    apb(0, `IDX_FS_A, 32'h0, 0);
    apb(0, 10'h34A, 32'h0, 1);
    apb(1, 10'h34A, 32'hFF, 1);
    apb(1, `IDX_FS_A, 32'h5A, 0);
    apb(1, `IDX_FS_B, 32'hA5, 0);
    @(negedge pclk);
    chk("fs_a", 32'h5A, {24'h0, fs_a});
    chk("fs_b", 32'hA5, {24'h0, fs_b});
    $display("test registers done");
    repeat (16)
    begin
      a = $urandom;
      b = $urandom;
      smp(a, b, a ^ 8'h80, b ^ 8'h80);
    end
    $display("test samples done");
    apb(1, 10'h344, 32'h05, 0);
    apb(1, 10'h349, 32'hFB, 0);
    smp(8'h80, 8'h80, 8'h05, 8'hFB);
    smp(8'hFF, 8'h00, 8'h7F, 8'h80);
    apb(1, 10'h346, 32'h10, 0);
    apb(1, 10'h348, 32'h20, 0);
    apb(1, `IDX_CTRL, 32'h01, 0);
    repeat (2) @(negedge pclk);
    chk("falling_edge", 32'h1, {31'h0, fes});
    smp(8'h80, 8'h80, 8'h10, 8'h20);
    $display("test trims done");
    apb(1, `IDX_CTRL, 32'h11, 0);
    repeat (3) @(negedge pclk);
    chk("input_sel", 32'h0, {31'h0, ais});
    apb(1, `IDX_CTRL, 32'h31, 0);
    k = 0;
    while (cal !== 1'b1 && k < 4)
    begin
      @(negedge pclk);
      k++;
    end
    chk("cal_start", 32'h1, {31'h0, cal});
    repeat (3) @(negedge pclk);
    chk("input_sel", 32'h1, {31'h0, ais});
    apb(0, `IDX_LIVE, 32'h10, 0);
    smp(8'h80, 8'h80, 8'h00, 8'hFB);
    $display("test calibration done");
    apb(1, `IDX_THRESH, 32'h4064, 0);
    apb(1, `IDX_MASK, 32'hF, 0);
    for (k = 0; k < 8; k++)
    begin
      apb(1, `IDX_CTRL, k << 1, 0);
      len_q.push_back(16'h0008 << k);
      hit();
      drain();
    end
    apb(1, `IDX_CTRL, 32'h0, 0);
    len_q.push_back(16'd11);
    hit();
    @(posedge pclk);
    hit();
    drain();
    apb(0, `IDX_STATUS, 32'hF, 0);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1, `IDX_STATUS, 32'hF, 0);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(0, `IDX_STATUS, 32'h0, 0);
    $display("test hold done");
    apb(1, `IDX_MASK, 32'h0, 0);
    apb(1, `IDX_THRESH, 32'h407C, 0);
    hit();
    repeat (20) @(posedge pclk);
    apb(0, `IDX_STATUS, 32'hD, 0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1, `IDX_THRESH, 32'h407B, 0);
    len_q.push_back(16'h0008);
    hit();
    drain();
    // clear of status lands on the edge that sets it
    len_q.push_back(16'h000A);
    core_a_raw <= 8'h00;
    core_b_raw <= 8'h00;
    apb(1, `IDX_STATUS, 32'hF, 0);
    core_a_raw <= 8'h80;
    core_b_raw <= 8'h80;
    apb(0, `IDX_STATUS, 32'hF, 0);
    drain();
    // most negative code reaches 127, core a at -123 does not
    apb(1, `IDX_STATUS, 32'hF, 0);
    apb(1, `IDX_THRESH, 32'h7F7F, 0);
    hit();
    repeat (12) @(posedge pclk);
    apb(0, `IDX_STATUS, 32'hC, 0);
    // single mode: only core b trips, receiver ors the flags
    apb(1, `IDX_CTRL, 32'h01, 0);
    len_q.push_back(16'h0008);
    @(posedge pclk);
    core_b_raw <= 8'h00;
    @(posedge pclk);
    core_b_raw <= 8'h80;
    drain();
    $display("test threshold done");
    repeat (4) @(posedge pclk);
    end_sim();
  end
endmodule
